// >>> src/cal_interval_timer.sv
// Calibration timer with retained interval register.
`timescale 1ns/10ps
module cal_interval_timer #(
    parameter int STEP_CYCLES = clk_ctrl_pkg::CAL_STEP_CYCLES
) (
    input wire logic clk,     // system clock
    input wire logic por_rst, // power-on reset, only reset of the interval register; system reset comes in as cal.clr
    cal_timer_if.timer cal    // control from register block
);
    import clk_ctrl_pkg::*;

    timer_regs_t s_ff;
    timer_regs_t nxt_s;

    // ****************************************************************
    // Quarter-second prescaler and interval countdown
    // ****************************************************************
    always_comb begin
        nxt_s         = s_ff;
        nxt_s.timeout = 1'b0;
        if (cal.iv_wr) begin
            nxt_s.interval = cal.iv_wdata;
        end
        if (cal.start) begin
            // A zero interval runs as one step, the shortest legal one.
            nxt_s.st     = T_RUN;
            nxt_s.presc  = 32'(STEP_CYCLES - 1);
            nxt_s.remain = (s_ff.interval == '0) ? 7'h01 : s_ff.interval;
        end else begin
            case (s_ff.st)
                T_IDLE: begin
                    nxt_s.presc = '0;
                end
                T_RUN: begin
                    if (cal.stop) begin
                        nxt_s.st = T_IDLE;
                    end else if (s_ff.presc == '0) begin
                        nxt_s.presc = 32'(STEP_CYCLES - 1);
                        if (s_ff.remain == 7'h01) begin
                            nxt_s.timeout = 1'b1;
                            nxt_s.st      = T_IDLE;
                        end else begin
                            nxt_s.remain = s_ff.remain - 7'h01;
                        end
                    end else begin
                        nxt_s.presc = s_ff.presc - 32'h1;
                    end
                end
                default: begin
                    nxt_s.st = T_IDLE;
                end
            endcase
        end
        // System reset stops counting but leaves the interval alone.
        if (cal.clr) begin
            nxt_s.st      = T_IDLE;
            nxt_s.presc   = '0;
            nxt_s.remain  = '0;
            nxt_s.timeout = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge por_rst) begin
        if (por_rst) begin
            s_ff <= '{st: T_IDLE, presc: 32'h0, remain: 7'h00,
                      interval: CAL_IV_RST, timeout: 1'b0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign cal.interval = s_ff.interval;
    assign cal.timeout  = s_ff.timeout;
    assign cal.running  = (s_ff.st == T_RUN);

    chk_iv_retained_clr: assert property (@(posedge clk)
        disable iff (por_rst)
        cal.clr && !cal.iv_wr |=> s_ff.interval == $past(s_ff.interval))
        else $error("interval lost on system reset");
    chk_timeout_from_run: assert property (@(posedge clk)
        disable iff (por_rst)
        s_ff.timeout |-> $past(s_ff.st) == T_RUN && s_ff.st == T_IDLE)
        else $error("timeout without a running timer");

endmodule : cal_interval_timer

// >>> src/cal_timer_if.sv
// Interface between the register block and the calibration timer.
`timescale 1ns/10ps
interface cal_timer_if;
    import clk_ctrl_pkg::*;
    logic                start;
    logic                stop;
    logic                clr;
    logic                iv_wr;
    logic [CAL_IV_W-1:0] iv_wdata;
    logic [CAL_IV_W-1:0] interval;
    logic                timeout;
    logic                running;

    modport ctrl (output start, stop, clr, iv_wr, iv_wdata,
                  input  interval, timeout, running);
    modport timer (input  start, stop, clr, iv_wr, iv_wdata,
                   output interval, timeout, running);
endinterface : cal_timer_if

// >>> src/clk_ctrl_pkg.sv
// Package with register map, field layout and timing constants.
package clk_ctrl_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam int          APB_AW       = 12;
    localparam logic [11:0] OFS_INTEN_SET = 12'h304;
    localparam logic [11:0] OFS_INTEN_CLR = 12'h308;
    localparam logic [11:0] OFS_INT_STAT  = 12'h30c;
    localparam logic [11:0] OFS_HF_RUN    = 12'h408;
    localparam logic [11:0] OFS_HF_STAT   = 12'h40c;
    localparam logic [11:0] OFS_LF_RUN    = 12'h414;
    localparam logic [11:0] OFS_LF_STAT   = 12'h418;
    localparam logic [11:0] OFS_LF_COPY   = 12'h41c;
    localparam logic [11:0] OFS_LF_SRC    = 12'h518;
    localparam logic [11:0] OFS_CAL_IV    = 12'h538;

    // ****************************************************************
    // Field layout
    // ****************************************************************
    localparam int NUM_EVT      = 4;
    localparam int BIT_FAST_UP  = 0;
    localparam int BIT_SLOW_UP  = 1;
    localparam int BIT_CAL_DONE = 2;
    localparam int BIT_CAL_TO   = 3;
    localparam int RUN_BIT      = 0;
    localparam int STAT_SRC_LSB = 0;
    localparam int STAT_RUN_BIT = 16;
    localparam int SRC_LSB      = 0;
    localparam int SRC_W        = 2;
    localparam int BYPASS_BIT   = 16;
    localparam int EXTERNAL_BIT = 17;
    localparam int CAL_IV_LSB   = 0;
    localparam int CAL_IV_W     = 7;
    localparam int SYNC_W       = 3;

    localparam logic [1:0] SRC_RC    = 2'h0;
    localparam logic [1:0] SRC_XTAL  = 2'h1;
    localparam logic [1:0] SRC_SYNTH = 2'h2;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [NUM_EVT-1:0]  INTEN_RST  = 4'h0;
    localparam logic [SRC_W-1:0]    LF_SRC_RST = 2'h0;
    localparam logic [CAL_IV_W-1:0] CAL_IV_RST = 7'h00;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_FREQ_HZ     = 20_000_000;
    localparam int CAL_STEP_MS     = 250;
    localparam int CAL_STEP_CYCLES = CLK_FREQ_HZ / 1000 * CAL_STEP_MS;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        T_IDLE = 2'b01,
        T_RUN  = 2'b10
    } timer_state_t;

    typedef struct packed {
        logic [SRC_W-1:0] src;
        logic             bypass;
        logic             ext;
    } lf_sel_t;

    typedef struct packed {
        logic [NUM_EVT-1:0] inten;
        logic [NUM_EVT-1:0] evt;
        logic               hf_run;
        logic               lf_run;
        lf_sel_t            lf_src;
        lf_sel_t            lf_copy;
        logic [SYNC_W-1:0]  hf_sync;
        logic [SYNC_W-1:0]  lf_sync;
        logic               hf_up;
        logic               lf_up;
        logic [31:0]        prdata;
    } ctrl_state_t;

    typedef struct packed {
        timer_state_t       st;
        logic [31:0]        presc;
        logic [CAL_IV_W-1:0] remain;
        logic [CAL_IV_W-1:0] interval;
        logic               timeout;
    } timer_regs_t;

endpackage : clk_ctrl_pkg

// >>> src/clock_ctrl_status_and_lf_source.sv
// Clock control status, interrupt enables and slow clock source block.
//
// Contract
// - Writing one to bit A of the enable-clear register disables fast-up irq.
// - Writing one to bit B of enable-clear disables slow-up irq.
// - Writing one to bit C of enable-clear disables calibration-done irq.
// - Writing one to bit D disables timeout irq; reading returns enable.
// - Fast clock run register shows the fast start task was triggered.
// - Slow clock run register shows the slow start task was triggered.
// - Slow start task captures the source selection into a readable copy.
// - Source field: 0 selects RC, 1 crystal, 2 synthesized.
// - Bypass bit one bypasses the crystal for rail-to-rail external clocks.
// - External bit selects external source; software keeps field at crystal.
// - External bit zero runs crystal with external input disabled.
// - Calibration interval survives ordinary resets.
// - Interval ranges from a quarter second to 31.75 seconds.
// - Enable-set register enables the same four interrupts, shared state.
// - Calibration-done event marks end of RC oscillator calibration.
// - Timeout event fires when the calibration timer expires.
`timescale 1ns/10ps
module clock_ctrl_status_and_lf_source #(
    parameter int CAL_STEP = clk_ctrl_pkg::CAL_STEP_CYCLES
) (
    input  wire logic                           clk,        // 20 MHz
    input  wire logic                           rst,        // async, high
    input  wire logic                           por_rst,    // power-on
    input  wire logic                           psel,       // APB select
    input  wire logic                           penable,    // APB enable
    input  wire logic                           pwrite,     // APB write
    input  wire logic [clk_ctrl_pkg::APB_AW-1:0] paddr,     // APB address
    input  wire logic [31:0]                    pwdata,     // APB wdata
    output logic      [31:0]                    prdata,     // APB rdata
    output logic                                pready,     // APB ready
    output logic                                pslverr,    // APB error
    input  wire logic                           fast_clock_start_task,
    input  wire logic                           fast_clock_stop_task,
    input  wire logic                           slow_clock_start_task,
    input  wire logic                           slow_clock_stop_task,
    input  wire logic                           cal_start_task, // timer
    input  wire logic                           cal_stop_task,  // timer
    input  wire logic                           fast_clock_up_event,
    input  wire logic                           slow_clock_up_event,
    input  wire logic                           cal_done_event, // RC cal
    input  wire logic                           fast_clock_running_pin,
    input  wire logic                           slow_clock_running_pin,
    output logic                                irq,        // level
    output logic [clk_ctrl_pkg::SRC_W-1:0]      lf_source,  // active src
    output logic                                lf_rc_en,   // RC osc on
    output logic                                lf_xtal_en, // crystal on
    output logic                                lf_synth_en, // synth on
    output logic                                lf_bypass_en, // bypass
    output logic                                lf_external_en // ext in
);
    import clk_ctrl_pkg::*;

    ctrl_state_t        s_ff;
    ctrl_state_t        nxt_s;
    cal_timer_if        cal ();
    logic               wr_acc;
    logic               rd_setup;
    logic               mapped;
    logic [NUM_EVT-1:0] evt_in;
    logic [31:0]        rd_word;
    logic [9:0]         widx;

    // ****************************************************************
    // Calibration timer
    // ****************************************************************
    // The interval register answers only to power-on reset; a system reset
    // reaches the timer as cal.clr and stops counting but leaves the interval in place.
    cal_interval_timer #(
        .STEP_CYCLES (CAL_STEP)
    ) u_timer (
        .clk     (clk),
        .por_rst (por_rst),
        .cal     (cal.timer)
    );

    assign cal.start    = cal_start_task;
    assign cal.stop     = cal_stop_task;
    assign cal.clr      = rst;
    assign cal.iv_wr    = wr_acc && (widx == OFS_CAL_IV[11:2]);
    assign cal.iv_wdata = pwdata[CAL_IV_LSB +: CAL_IV_W];

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    // Zero wait states: the read word is prepared in the setup cycle.
    // An unmapped access is flagged at once, since pready never waits.
    assign widx     = paddr[11:2];
    assign wr_acc   = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;

    always_comb begin
        case (widx)
            OFS_INTEN_SET[11:2], OFS_INTEN_CLR[11:2], OFS_INT_STAT[11:2],
            OFS_HF_RUN[11:2], OFS_HF_STAT[11:2], OFS_LF_RUN[11:2],
            OFS_LF_STAT[11:2], OFS_LF_COPY[11:2], OFS_LF_SRC[11:2],
            OFS_CAL_IV[11:2]: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // Events and tasks come from logic on this clock, so they pass no
    // synchroniser; only the two running pins need one.
    assign evt_in[BIT_FAST_UP]  = fast_clock_up_event;
    assign evt_in[BIT_SLOW_UP]  = slow_clock_up_event;
    assign evt_in[BIT_CAL_DONE] = cal_done_event;
    assign evt_in[BIT_CAL_TO]   = cal.timeout;

    // ****************************************************************
    // Read multiplexer
    // ****************************************************************
    always_comb begin
        rd_word = 32'h0;
        case (widx)
            OFS_INTEN_SET[11:2], OFS_INTEN_CLR[11:2]: begin
                rd_word[NUM_EVT-1:0] = s_ff.inten;
            end
            OFS_INT_STAT[11:2]: begin
                rd_word[NUM_EVT-1:0] = s_ff.evt;
            end
            OFS_HF_RUN[11:2]: begin
                rd_word[RUN_BIT] = s_ff.hf_run;
            end
            OFS_HF_STAT[11:2]: begin
                rd_word[STAT_RUN_BIT] = s_ff.hf_up;
            end
            OFS_LF_RUN[11:2]: begin
                rd_word[RUN_BIT] = s_ff.lf_run;
            end
            OFS_LF_STAT[11:2]: begin
                rd_word[STAT_SRC_LSB +: SRC_W] = s_ff.lf_copy.src;
                rd_word[STAT_RUN_BIT]          = s_ff.lf_up;
            end
            OFS_LF_COPY[11:2]: begin
                rd_word[SRC_LSB +: SRC_W] = s_ff.lf_copy.src;
                rd_word[BYPASS_BIT]       = s_ff.lf_copy.bypass;
                rd_word[EXTERNAL_BIT]     = s_ff.lf_copy.ext;
            end
            OFS_LF_SRC[11:2]: begin
                rd_word[SRC_LSB +: SRC_W] = s_ff.lf_src.src;
                rd_word[BYPASS_BIT]       = s_ff.lf_src.bypass;
                rd_word[EXTERNAL_BIT]     = s_ff.lf_src.ext;
            end
            OFS_CAL_IV[11:2]: begin
                rd_word[CAL_IV_LSB +: CAL_IV_W] = cal.interval;
            end
            default: begin
                rd_word = 32'h0;
            end
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        nxt_s = s_ff;

        // Run indicators follow the tasks; a start beats a stop.
        if (fast_clock_stop_task) begin
            nxt_s.hf_run = 1'b0;
        end
        if (fast_clock_start_task) begin
            nxt_s.hf_run = 1'b1;
        end
        if (slow_clock_stop_task) begin
            nxt_s.lf_run = 1'b0;
        end
        if (slow_clock_start_task) begin
            nxt_s.lf_run  = 1'b1;
            nxt_s.lf_copy = s_ff.lf_src;
        end

        // Oscillator running flags: third and second stage must agree.
        // A pin that toggles faster than the stages settle keeps its flag.
        nxt_s.hf_sync = {s_ff.hf_sync[SYNC_W-2:0], fast_clock_running_pin};
        nxt_s.lf_sync = {s_ff.lf_sync[SYNC_W-2:0], slow_clock_running_pin};
        if (s_ff.hf_sync[2] == s_ff.hf_sync[1]) begin
            nxt_s.hf_up = s_ff.hf_sync[2];
        end
        if (s_ff.lf_sync[2] == s_ff.lf_sync[1]) begin
            nxt_s.lf_up = s_ff.lf_sync[2];
        end

        // Register writes; run, clock status and copy words take none.
        if (wr_acc) begin
            case (widx)
                OFS_INTEN_SET[11:2]: begin
                    nxt_s.inten = s_ff.inten | pwdata[NUM_EVT-1:0];
                end
                OFS_INTEN_CLR[11:2]: begin
                    nxt_s.inten = s_ff.inten & ~pwdata[NUM_EVT-1:0];
                end
                OFS_INT_STAT[11:2]: begin
                    nxt_s.evt = s_ff.evt & ~pwdata[NUM_EVT-1:0];
                end
                OFS_LF_SRC[11:2]: begin
                    nxt_s.lf_src.src    = pwdata[SRC_LSB +: SRC_W];
                    nxt_s.lf_src.bypass = pwdata[BYPASS_BIT];
                    nxt_s.lf_src.ext    = pwdata[EXTERNAL_BIT];
                end
                default: begin
                    nxt_s.inten = s_ff.inten;
                end
            endcase
        end

        // A new event wins over a clear in the same cycle.
        nxt_s.evt = nxt_s.evt | evt_in;

        if (rd_setup) begin
            nxt_s.prdata = rd_word;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_ff <= '{inten: INTEN_RST, evt: 4'h0, hf_run: 1'b0,
                      lf_run: 1'b0,
                      lf_src: '{src: LF_SRC_RST, bypass: 1'b0, ext: 1'b0},
                      lf_copy: '{src: LF_SRC_RST, bypass: 1'b0, ext: 1'b0},
                      hf_sync: 3'h0, lf_sync: 3'h0, hf_up: 1'b0,
                      lf_up: 1'b0, prdata: 32'h0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign prdata  = s_ff.prdata;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign irq     = |(s_ff.evt & s_ff.inten);

    // The oscillator is driven from the copy taken at start, so a later
    // rewrite of the source word cannot disturb a running slow clock.
    assign lf_source    = s_ff.lf_copy.src;
    assign lf_rc_en     = s_ff.lf_run && (s_ff.lf_copy.src == SRC_RC);
    assign lf_xtal_en   = s_ff.lf_run && (s_ff.lf_copy.src == SRC_XTAL);
    assign lf_synth_en  = s_ff.lf_run && (s_ff.lf_copy.src == SRC_SYNTH);
    assign lf_external_en = s_ff.lf_run && s_ff.lf_copy.ext
                            && (s_ff.lf_copy.src == SRC_XTAL);
    assign lf_bypass_en = lf_external_en && s_ff.lf_copy.bypass;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_clr_fast_up: assert property (
        wr_acc && widx == OFS_INTEN_CLR[11:2] && pwdata[BIT_FAST_UP]
        |=> !s_ff.inten[BIT_FAST_UP])
        else $error("fast-up enable not cleared");

    chk_clr_slow_up: assert property (
        wr_acc && widx == OFS_INTEN_CLR[11:2] && pwdata[BIT_SLOW_UP]
        |=> !s_ff.inten[BIT_SLOW_UP])
        else $error("slow-up enable not cleared");

    chk_clr_cal_done: assert property (
        wr_acc && widx == OFS_INTEN_CLR[11:2] && pwdata[BIT_CAL_DONE]
        |=> !s_ff.inten[BIT_CAL_DONE])
        else $error("calibration-done enable not cleared");

    chk_clr_read_back: assert property (
        rd_setup && widx == OFS_INTEN_CLR[11:2]
        |=> prdata[BIT_CAL_TO] == $past(s_ff.inten[BIT_CAL_TO]))
        else $error("enable read-back wrong");

    chk_set_enables: assert property (
        wr_acc && widx == OFS_INTEN_SET[11:2] && pwdata[BIT_CAL_TO]
        |=> s_ff.inten[BIT_CAL_TO] ##1 s_ff.inten[BIT_CAL_TO] || wr_acc)
        else $error("timeout enable not set");

    chk_fast_run_set: assert property (
        fast_clock_start_task |=> s_ff.hf_run)
        else $error("fast run flag missing");

    chk_slow_run_copy: assert property (
        slow_clock_start_task
        |=> s_ff.lf_run && s_ff.lf_copy == $past(s_ff.lf_src))
        else $error("slow run flag or copy wrong");

    chk_ro_ignored: assert property (
        wr_acc && widx == OFS_HF_RUN[11:2] && !fast_clock_start_task
        && !fast_clock_stop_task |=> $stable(s_ff.hf_run))
        else $error("read-only run word changed by write");

    chk_ext_needs_bit: assert property (
        !s_ff.lf_copy.ext |-> !lf_external_en && !lf_bypass_en)
        else $error("external input on with external bit clear");

    chk_event_irq: assert property (
        cal.timeout && !wr_acc ##1 s_ff.inten[BIT_CAL_TO] |-> irq)
        else $error("timeout event did not raise irq");

    // ****************************************************************
    // Checks on the slow clock outputs and run word, the interval, the done event and enable-clear
    // ****************************************************************

    chk_source_out: assert property (
        slow_clock_start_task |=> lf_source == $past(s_ff.lf_src.src))
        else $error("slow source output not taken at start");

    chk_rc_select: assert property (
        s_ff.lf_run && lf_source == SRC_RC |-> lf_rc_en && !lf_synth_en)
        else $error("resistor-capacitor source not selected");

    chk_bypass_needs_ext: assert property (
        lf_bypass_en |-> lf_external_en && s_ff.lf_copy.bypass)
        else $error("bypass on without external input");

    chk_iv_write: assert property (
        disable iff (rst || por_rst)
        cal.iv_wr |=> cal.interval == $past(pwdata[CAL_IV_LSB +: CAL_IV_W]))
        else $error("calibration interval write lost");

    chk_event_sticky: assert property (
        cal_done_event |=> s_ff.evt[BIT_CAL_DONE])
        else $error("calibration-done event not recorded");

    chk_slow_ro: assert property (
        wr_acc && widx == OFS_LF_RUN[11:2] && !slow_clock_start_task
        && !slow_clock_stop_task |=> $stable(s_ff.lf_run))
        else $error("read-only slow run word changed by write");

    chk_clr_no_set: assert property (
        wr_acc && widx == OFS_INTEN_CLR[11:2]
        |=> (s_ff.inten & ~$past(s_ff.inten)) == '0)
        else $error("enable-clear write set an enable");

endmodule : clock_ctrl_status_and_lf_source

// >>> test/clock_ctrl_status_and_lf_source_tb.sv
// Self-checking testbench for the clock control register block.
`timescale 1ns/10ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin \
    miscompares++; $display("mismatch %s exp %h got %h", nm, e, s); end end
module clock_ctrl_status_and_lf_source_tb;
    import clk_ctrl_pkg::*;
    localparam int STEP = 4;
    logic        clk, rst, por_rst, psel, penable, pwrite;
    logic        pready, pslverr, irq, err, hf_pin, lf_pin;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [8:0]  tk;
    logic [1:0]  lf_source;
    logic [4:0]  en;
    int          miscompares = 0;
    int          n_tests = 0;

    clock_ctrl_status_and_lf_source #(.CAL_STEP(STEP)) DUT (
        .clk(clk), .rst(rst), .por_rst(por_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fast_clock_start_task(tk[0]),
        .fast_clock_stop_task(tk[1]), .slow_clock_start_task(tk[2]),
        .slow_clock_stop_task(tk[3]), .cal_start_task(tk[4]),
        .cal_stop_task(tk[5]), .fast_clock_up_event(tk[6]),
        .slow_clock_up_event(tk[7]), .cal_done_event(tk[8]),
        .fast_clock_running_pin(hf_pin), .slow_clock_running_pin(lf_pin),
        .irq(irq), .lf_source(lf_source), .lf_rc_en(en[4]),
        .lf_xtal_en(en[3]), .lf_synth_en(en[2]), .lf_bypass_en(en[1]),
        .lf_external_en(en[0]));

    // ****************************************************************
    // Bus, pulse and expectation helpers
    // ****************************************************************
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic pulse(input int i);
        tk <= 9'h1 << i;
        @(posedge clk);
        tk <= 9'h0;
        @(posedge clk);
    endtask : pulse

    // Oscillators follow the copy; external input only with crystal.
    function automatic logic [4:0] exp_en(input logic [1:0] s,
                                          input logic b, input logic x);
        logic xe;
        xe = x & (s == SRC_XTAL);
        return {s == SRC_RC, s == SRC_XTAL, s == SRC_SYNTH, xe & b, xe};
    endfunction : exp_en

    task automatic end_sim;
        $display("tests %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        end_sim();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin : main
        logic [3:0] m;
        logic [6:0] iv;
        logic       b, x;
        int         n;
        rst = 1'b1; por_rst = 1'b1; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0; tk = 9'h0;
        hf_pin = 1'b0;
        lf_pin = $urandom(32'h46ded1ef);
        repeat (12) @(posedge clk);
        rst <= 1'b0; por_rst <= 1'b0;
        @(posedge clk);
        apb(0, OFS_LF_SRC, 0, q); `CHK("lf_src_rst", 32'h0, q)
        apb(0, OFS_INTEN_CLR, 0, q); `CHK("inten_rst", 32'h0, q)
        apb(0, OFS_CAL_IV, 0, q); `CHK("cal_iv_rst", 32'h0, q)
        $display("test reset done");
        m = $urandom;
        apb(1, OFS_INTEN_SET, 32'hf, q);
        apb(1, OFS_INTEN_CLR, {28'h0, m}, q);
        apb(0, OFS_INTEN_CLR, 0, q); `CHK("inten_clr", {28'h0, ~m}, q)
        apb(0, OFS_INTEN_SET, 0, q); `CHK("inten_set", {28'h0, ~m}, q)
        apb(1, OFS_INTEN_CLR, 32'hf, q);
        for (int e = 0; e < 3; e++) begin
            apb(1, OFS_INTEN_SET, 32'h1 << e, q);
            pulse(6 + e);
            `CHK("irq_set", 1'b1, irq)
            apb(0, OFS_INT_STAT, 0, q); `CHK("status", 32'h1 << e, q)
            apb(1, OFS_INTEN_CLR, 32'h1 << e, q);
            `CHK("irq_masked", 1'b0, irq)
            apb(1, OFS_INT_STAT, 32'hf, q);
        end
        $display("test interrupts done");
        apb(1, OFS_CAL_IV, 32'h7f, q);
        apb(0, OFS_CAL_IV, 0, q); `CHK("iv_max", 32'h7f, q)
        iv = 7'($urandom_range(1, 5));
        apb(1, OFS_CAL_IV, {25'h0, iv}, q);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(0, OFS_CAL_IV, 0, q); `CHK("iv_kept", {25'h0, iv}, q)
        apb(1, OFS_INTEN_SET, 32'h8, q);
        pulse(4);
        for (n = 0; n < 200 && irq !== 1'b1; n++) @(posedge clk);
        `CHK("timeout", 1'b1, irq)
        `CHK("span", 1'b1, n >= iv * STEP - 2 && n <= iv * STEP + 2)
        pulse(5);
        por_rst <= 1'b1;
        @(posedge clk);
        por_rst <= 1'b0;
        @(posedge clk);
        apb(0, OFS_CAL_IV, 0, q); `CHK("iv_por", 32'h0, q)
        $display("test timer done");
        for (int s = 0; s < 3; s++) begin
            b = $urandom;
            x = (s == 1) ? 1'($urandom) : 1'b0;
            apb(1, OFS_LF_SRC, {14'h0, x, b, 14'h0, 2'(s)}, q);
            apb(0, OFS_LF_SRC, 0, q);
            `CHK("lf_src", {14'h0, x, b, 14'h0, 2'(s)}, q)
            pulse(2);
            `CHK("osc_en", exp_en(2'(s), b, x), en)
            apb(1, OFS_LF_SRC, {30'h0, 2'(2 - s)}, q);
            `CHK("copy_held", 2'(s), lf_source)
            apb(0, OFS_LF_STAT, 0, q); `CHK("copy_stat", 2'(s), q[1:0])
            `CHK("lf_up", lf_pin, q[16])
            apb(1, OFS_LF_RUN, 0, q);
            apb(0, OFS_LF_RUN, 0, q); `CHK("lf_run", 32'h1, q)
            pulse(3);
        end
        $display("test slow source done");
        hf_pin <= 1'b1;
        pulse(0);
        apb(1, OFS_HF_RUN, 0, q);
        apb(0, OFS_HF_RUN, 0, q); `CHK("hf_run", 32'h1, q)
        apb(0, OFS_HF_STAT, 0, q); `CHK("hf_stat", 1'b1, q[16])
        apb(0, 12'h000, 0, q);
        `CHK("unmapped_err", 1'b1, err)
        `CHK("unmapped_rd", 32'h0, q)
        $display("test fast run done");
        end_sim();
    end
endmodule : clock_ctrl_status_and_lf_source_tb
